// file: verilog/rlt_timer_bank.sv
// six reload timers behind an axi4-lite register slave
// What this block does
// - six timers, nothing shared between them
// - each has 16-bit counter and reload
// - prescaler divides clock by 2, 4, 8, 16
// - divider bits 3:2, 00 is divide by two
// - count one ends on next tick
// - count zero wraps to all ones
// - period is ratio times reload over clock
// - single pass stops at zero, clears enable
// - continuous reloads at zero, keeps counting
// - continuous runs until enable is cleared
// - count reads leave the timer untouched
// - flag sets at zero or at reload
// - flag only on the step from count one
// - bit 6 lets flag drive interrupt line
// - control read clears flag and request
// - bit 1 is reload and restart enable
// - bit 0 enables the timer
// - writing bit 1 loads reload, restarts
// - bit 4 selects continuous mode
// - low byte read latches high byte
`timescale 1ns/1ps
module rlt_timer_bank #(
  parameter int NUM_TIMERS = rlt_pkg::NUM_TIMERS_DEF,
  parameter int ADDR_W = rlt_pkg::ADDR_W_DEF
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [NUM_TIMERS-1:0] TIMER_IRQ
);
  import rlt_pkg::*;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // {hit, timer, sub} for a byte address
  function automatic logic [5:0] reg_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    logic [ADDR_W-3:0] off;
    idx = a[ADDR_W-1:2];
    off = idx - (ADDR_W-2)'(REG_BASE_IDX);
    if (idx >= (ADDR_W-2)'(REG_BASE_IDX) && off < (ADDR_W-2)'(NUM_TIMERS * REG_STRIDE)) begin
      reg_decode = {1'b1, 3'(off / REG_STRIDE), 2'(off % REG_STRIDE)};
    end else begin
      reg_decode = 6'h00;
    end
  endfunction

  // prescaler tap: one tick every 2, 4, 8 or 16 cycles
  function automatic logic pre_tick(input logic [PRE_W-1:0] p, input logic [1:0] d);
    case (d)
      DIV_2: pre_tick = p[0];
      DIV_4: pre_tick = &p[1:0];
      DIV_8: pre_tick = &p[2:0];
      default: pre_tick = &p;
    endcase
  endfunction

  // -------------------------------------------------------------
  // bus slave state
  // -------------------------------------------------------------
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic wr_go;
  logic rd_go;
  logic [5:0] wdec;
  logic [5:0] rdec;

  // -------------------------------------------------------------
  // timer state, one slot per timer
  // -------------------------------------------------------------
  logic [NUM_TIMERS-1:0] en_r;
  logic [NUM_TIMERS-1:0] rst_en_r;
  logic [NUM_TIMERS-1:0] mode_r;
  logic [NUM_TIMERS-1:0] ie_r;
  logic [NUM_TIMERS-1:0] flag_r;
  logic [NUM_TIMERS-1:0] irq_r;
  logic [1:0] div_r [NUM_TIMERS];
  logic [PRE_W-1:0] pre_r [NUM_TIMERS];
  logic [CNT_W-1:0] cnt_r [NUM_TIMERS];
  logic [CNT_W-1:0] rld_r [NUM_TIMERS];
  logic [7:0] hi_latch_r [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] wctl;
  logic [NUM_TIMERS-1:0] wlow;
  logic [NUM_TIMERS-1:0] whigh;
  logic [NUM_TIMERS-1:0] rctl;
  logic [NUM_TIMERS-1:0] rlow;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] restart;
  logic [NUM_TIMERS-1:0] fset;
  logic [NUM_TIMERS-1:0] flag_nxt;
  logic [NUM_TIMERS-1:0] ie_nxt;

  assign wdec = reg_decode(aw_addr_r);
  assign rdec = reg_decode(S_AXI_ARADDR);
  assign wr_go = !awready_r && !wready_r && !bvalid_r;
  assign rd_go = S_AXI_ARVALID && arready_r;

  // -------------------------------------------------------------
  // per-timer strobes and next values
  // -------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      wctl[t] = wr_go && wdec[5] && wdec[4:2] == 3'(t) && w_lane0_r && wdec[1:0] == SUB_CTL;
      wlow[t] = wr_go && wdec[5] && wdec[4:2] == 3'(t) && w_lane0_r && wdec[1:0] == SUB_LOW;
      whigh[t] = wr_go && wdec[5] && wdec[4:2] == 3'(t) && w_lane0_r && wdec[1:0] == SUB_HIGH;
      rctl[t] = rd_go && rdec[5] && rdec[4:2] == 3'(t) && rdec[1:0] == SUB_CTL;
      rlow[t] = rd_go && rdec[5] && rdec[4:2] == 3'(t) && rdec[1:0] == SUB_LOW;
      tick[t] = en_r[t] && pre_tick(pre_r[t], div_r[t]);
      restart[t] = wctl[t] && w_data_r[CTL_RST_BIT];
      fset[t] = tick[t] && cnt_r[t] == COUNT_ONE;
      flag_nxt[t] = fset[t] | (flag_r[t] & ~rctl[t]);
      ie_nxt[t] = wctl[t] ? w_data_r[CTL_IE_BIT] : ie_r[t];
    end
  end

  // -------------------------------------------------------------
  // write channels
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (wr_go) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else begin
      if (S_AXI_AWVALID && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_r) begin
        wready_r <= 1'b0;
        w_data_r <= S_AXI_WDATA[7:0];
        w_lane0_r <= S_AXI_WSTRB[0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wdec[5] ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // read channels
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= rdec[5] ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= 32'h0000_0000;
      if (rdec[5]) begin
        case (rdec[1:0])
          SUB_CTL: begin
            rdata_r[CTL_FLAG_BIT] <= flag_r[rdec[4:2]];
            rdata_r[CTL_IE_BIT] <= ie_r[rdec[4:2]];
            rdata_r[CTL_MODE_BIT] <= mode_r[rdec[4:2]];
            rdata_r[CTL_DIV_LSB+1:CTL_DIV_LSB] <= div_r[rdec[4:2]];
            rdata_r[CTL_RST_BIT] <= rst_en_r[rdec[4:2]];
            rdata_r[CTL_EN_BIT] <= en_r[rdec[4:2]];
          end
          SUB_LOW: rdata_r[7:0] <= cnt_r[rdec[4:2]][7:0];
          SUB_HIGH: rdata_r[7:0] <= hi_latch_r[rdec[4:2]];
          default: rdata_r[7:0] <= 8'h00;
        endcase
      end
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // control fields
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (!RESET_N) begin
        en_r[t] <= CTL_RESET[CTL_EN_BIT];
        rst_en_r[t] <= CTL_RESET[CTL_RST_BIT];
        mode_r[t] <= CTL_RESET[CTL_MODE_BIT];
        ie_r[t] <= CTL_RESET[CTL_IE_BIT];
        div_r[t] <= CTL_RESET[CTL_DIV_LSB+1:CTL_DIV_LSB];
      end else if (wctl[t]) begin
        en_r[t] <= w_data_r[CTL_EN_BIT];
        rst_en_r[t] <= w_data_r[CTL_RST_BIT];
        mode_r[t] <= w_data_r[CTL_MODE_BIT];
        ie_r[t] <= w_data_r[CTL_IE_BIT];
        div_r[t] <= w_data_r[CTL_DIV_LSB+1:CTL_DIV_LSB];
      end else if (fset[t] && !mode_r[t]) begin
        en_r[t] <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // flag and interrupt request
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (!RESET_N) begin
        flag_r[t] <= CTL_RESET[CTL_FLAG_BIT];
        irq_r[t] <= 1'b0;
      end else begin
        flag_r[t] <= flag_nxt[t];
        irq_r[t] <= flag_nxt[t] & ie_nxt[t];
      end
    end
  end

  // -------------------------------------------------------------
  // reload values
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (!RESET_N) begin
        rld_r[t] <= RELOAD_RESET;
      end else if (wlow[t]) begin
        rld_r[t][7:0] <= w_data_r;
      end else if (whigh[t]) begin
        rld_r[t][15:8] <= w_data_r;
      end
    end
  end

  // -------------------------------------------------------------
  // prescaler and downcounter
  // -------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (!RESET_N) begin
        pre_r[t] <= PRE_RESET;
      end else if (restart[t] || !en_r[t]) begin
        pre_r[t] <= PRE_RESET;
      end else begin
        pre_r[t] <= pre_r[t] + 4'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (!RESET_N) begin
        cnt_r[t] <= COUNT_RESET;
      end else if (restart[t]) begin
        cnt_r[t] <= rld_r[t];
      end else if (fset[t]) begin
        cnt_r[t] <= mode_r[t] ? rld_r[t] : COUNT_RESET;
      end else if (tick[t]) begin
        cnt_r[t] <= cnt_r[t] - 16'h0001;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (!RESET_N) begin
        hi_latch_r[t] <= 8'h00;
      end else if (rlow[t]) begin
        hi_latch_r[t] <= cnt_r[t][15:8];
      end
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RRESP = rresp_r;
  assign S_AXI_RDATA = rdata_r;
  assign TIMER_IRQ = irq_r;
endmodule

// file: verilog/rlt_pkg.sv
// constants shared by the reload timer bank
package rlt_pkg;
  // -------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------
  localparam int NUM_TIMERS_DEF = 6;
  localparam int CNT_W = 16;
  localparam int PRE_W = 4;
  localparam int ADDR_W_DEF = 12;
  // -------------------------------------------------------------
  // register map, word indices
  // -------------------------------------------------------------
  localparam logic [7:0] REG_BASE_IDX = 8'h80;
  localparam int REG_STRIDE = 3;
  localparam logic [1:0] SUB_CTL = 2'h0;
  localparam logic [1:0] SUB_LOW = 2'h1;
  localparam logic [1:0] SUB_HIGH = 2'h2;
  // -------------------------------------------------------------
  // control field positions
  // -------------------------------------------------------------
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_RST_BIT = 1;
  localparam int CTL_DIV_LSB = 2;
  localparam int CTL_MODE_BIT = 4;
  localparam int CTL_IE_BIT = 6;
  localparam int CTL_FLAG_BIT = 7;
  localparam logic [1:0] DIV_2 = 2'h0;
  localparam logic [1:0] DIV_4 = 2'h1;
  localparam logic [1:0] DIV_8 = 2'h2;
  localparam logic [1:0] DIV_16 = 2'h3;
  // -------------------------------------------------------------
  // reset values and counts
  // -------------------------------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [3:0] PRE_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: testbench/rlt_timer_bank_monitor.sv
// bus and interrupt checker for the reload timer bank
`timescale 1ns/1ps
module rlt_timer_bank_monitor import rlt_pkg::*; #(
  parameter int NUM_TIMERS = 6,
  parameter int ADDR_W = 12
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NUM_TIMERS-1:0] TIMER_IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_irq_reset: assert property ($past(!RESET_N) |-> TIMER_IRQ == '0)
    else $error("interrupt request not clear after reset");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before handshake");
  a_read_prompt: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  a_write_done: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write response timing wrong");
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_bad_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'hffc
    |=> S_AXI_RRESP == RESP_SLVERR) else $error("unmapped read not refused");
  a_flag_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && TIMER_IRQ[0] &&
    S_AXI_ARADDR == 12'h200 |=> S_AXI_RDATA[CTL_FLAG_BIT]) else $error("flag bit missing");
  a_aw_drop: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("write address ready not dropped");
  a_w_drop: assert property (S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_WREADY)
    else $error("write data ready not dropped");
endmodule
bind rlt_timer_bank rlt_timer_bank_monitor #(.NUM_TIMERS(NUM_TIMERS), .ADDR_W(ADDR_W)) i_mon (
  .REF_CLK, .RESET_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_IRQ);

// file: testbench/rlt_host_model.sv
// axi4-lite host that reaches the timer registers
`timescale 1ns/1ps
module rlt_host_model (
  input wire logic REF_CLK,
  output logic [11:0] S_AXI_AWADDR,
  output logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  output logic [31:0] S_AXI_WDATA,
  output logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  output logic S_AXI_BREADY,
  output logic [11:0] S_AXI_ARADDR,
  output logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  output logic S_AXI_RREADY
);
  initial {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = '0;
  initial {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!(S_AXI_BVALID && S_AXI_BREADY));
    S_AXI_BREADY <= 1'b0;
    // released payload shows the inverse, not the last value
    S_AXI_AWADDR <= ~a;
    S_AXI_WDATA <= ~{24'h0, d};
  endtask
  task rd(input logic [11:0] a);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!(S_AXI_RVALID && S_AXI_RREADY));
    S_AXI_RREADY <= 1'b0;
    S_AXI_ARADDR <= ~a;
  endtask
endmodule

// file: testbench/rlt_timer_bank_tb.sv
// self-checking bench for the reload timer bank
`timescale 1ns/1ps
module rlt_timer_bank_tb;
  import rlt_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [5:0] TIMER_IRQ;
  logic [33:0] eq[$], mq[$], m;
  logic [1:0] bq[$];
  int mismatches = 0, checks = 0, cyc = 0;
  always #4 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) cyc <= cyc + 1;
  rlt_timer_bank i_rlt_timer_bank (.REF_CLK, .RESET_N, .S_AXI_AWADDR, .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'h1), .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_IRQ);
  rlt_host_model i_rlt_host_model (.REF_CLK, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY);
  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // result watcher: oldest note against each answer
  always @(posedge REF_CLK) begin
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      m = mq.pop_front();
      check({S_AXI_RRESP, S_AXI_RDATA} & ~m, eq.pop_front() & ~m);
    end
    if (S_AXI_BVALID && S_AXI_BREADY) check({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
  end
  function automatic logic [11:0] ad(int t, int s);
    return 12'h200 + 12'(12 * t + 4 * s);
  endfunction
  task rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] dm, input logic [1:0] r);
    eq.push_back({r, 24'h0, d});
    mq.push_back({26'h0, dm});
    i_rlt_host_model.rd(a);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    i_rlt_host_model.wr(a, d);
  endtask
  task wait_irq(input int t, output int at);
    int n;
    for (n = 0; n < 3000 && TIMER_IRQ[t] !== 1'b1; n++) @(posedge REF_CLK);
    at = cyc;
    if (n >= 3000) check(34'h0, 34'h1);
  endtask
  initial begin
    int t, a0, a1;
    logic [7:0] c, rl;
    void'($urandom(32'h8a1e));
    repeat (20) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    for (t = 0; t < 6; t++) begin
      rd(ad(t, 0), CTL_RESET, 8'h00, RESP_OKAY);
      rd(ad(t, 1), COUNT_RESET[7:0], 8'h00, RESP_OKAY);
    end
    rd(12'hffc, 8'h00, 8'hff, RESP_SLVERR);
    wr(12'hffc, 8'h5a, RESP_SLVERR);
    for (t = 0; t < 4; t++) begin
      rl = (t == 3) ? 8'h01 : 8'h04 + 8'($urandom_range(11));
      c = 8'h53 | 8'(t << CTL_DIV_LSB);
      wr(ad(t, 1), rl, RESP_OKAY);
      wr(ad(t, 2), 8'h00, RESP_OKAY);
      wr(ad(t, 0), c, RESP_OKAY);
      wait_irq(t, a0);
      rd(ad(t, 0), c | 8'h80, 8'h00, RESP_OKAY);
      check({28'h0, TIMER_IRQ}, 34'h0);
      wait_irq(t, a1);
      check(34'(a1 - a0), 34'((2 << t) * rl));
      check({28'h0, TIMER_IRQ}, {28'h0, 6'h1 << t});
      wr(ad(t, 0), 8'h00, RESP_OKAY);
      rd(ad(t, 0), 8'h80, 8'h00, RESP_OKAY);
    end
    wr(ad(4, 1), 8'h01, RESP_OKAY);
    wr(ad(4, 2), 8'h00, RESP_OKAY);
    wr(ad(4, 0), 8'h43, RESP_OKAY);
    wait_irq(4, a0);
    rd(ad(4, 0), 8'hc2, 8'h00, RESP_OKAY);
    repeat (40) @(posedge REF_CLK);
    rd(ad(4, 1), 8'h00, 8'h00, RESP_OKAY);
    wr(ad(4, 0), 8'h41, RESP_OKAY);
    rd(ad(4, 1), 8'h00, 8'hff, RESP_OKAY);
    rd(ad(4, 2), 8'hff, 8'h00, RESP_OKAY);
    check({28'h0, TIMER_IRQ}, 34'h0);
    wr(ad(4, 0), 8'h00, RESP_OKAY);
    end_of_test;
  end
  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end
endmodule
